// ==== src/ccr_charger_config_register_bank.sv ====
// I2C target holding the charger configuration, charge-current and precharge/termination registers.
`timescale 1ns/100ps
module ccr_charger_config_register_bank #(
    parameter logic [6:0] DEV_ADDR = ccr_pkg::CCR_DEV_ADDR
) (
    input  wire logic               clk,             // 10 MHz clock
    input  wire logic               rst_n,           // Asynchronous reset, active low
    input  wire logic               scl_i,           // I2C clock pin level
    input  wire logic               sda_i,           // I2C data pin level
    output logic                    sda_o,           // I2C data drive value
    output logic                    sda_oe,          // High while pulling data low
    input  wire logic               wdog_expired,    // Watchdog expiry pulse, same clock
    output logic                    wdog_restart,    // One-cycle watchdog restart pulse
    output logic                    host_mode,       // High in host mode
    output ccr_pkg::ccr_regs_s      regs_view,       // Stored register bytes
    output ccr_pkg::ccr_apply_s     apply            // Decoded settings as applied
);

    // Addresses in the general-call and reserved ranges cannot be served.
    if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : g_bad_addr
        $error("DEV_ADDR lies in a reserved I2C address range.");
    end

    localparam ccr_pkg::ccr_regs_s REGS_RST = '{poc: ccr_pkg::CCR_POC_RST,
                                                ccc: ccr_pkg::CCR_CCC_RST,
                                                ptc: ccr_pkg::CCR_PTC_RST};

    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic sda_now;

    assign sda_now   = sda_sync_reg[1];
    assign scl_rise  = scl_sync_reg[1] & ~scl_sync_reg[2];
    assign scl_fall  = ~scl_sync_reg[1] & scl_sync_reg[2];
    assign bus_start = scl_sync_reg[1] & scl_sync_reg[2] & sda_sync_reg[2] & ~sda_now;
    assign bus_stop  = scl_sync_reg[1] & scl_sync_reg[2] & ~sda_sync_reg[2] & sda_now;

    ccr_pkg::ccr_state_e state_reg, state_next;
    logic [7:0]          sr_reg, sr_next;
    logic [3:0]          cnt_reg, cnt_next;
    logic [7:0]          ptr_reg, ptr_next;
    logic                rnw_reg, rnw_next;
    logic                nack_reg, nack_next;
    logic                oe_reg, oe_next;
    logic                wdog_reg, wdog_next;
    logic                host_reg, host_next;
    ccr_pkg::ccr_regs_s  regs_reg, regs_next;
    ccr_pkg::ccr_apply_s apply_reg, apply_next;

    logic        byte_done;
    logic        wr_commit;
    logic [7:0]  wr_data;
    logic [12:0] fast_raw;
    logic [11:0] pre_raw;

    function automatic logic ptr_valid(input logic [7:0] p);
        ptr_valid = (p == ccr_pkg::CCR_OFS_POC) || (p == ccr_pkg::CCR_OFS_CCC) || (p == ccr_pkg::CCR_OFS_PTC);
    endfunction : ptr_valid

    function automatic logic [7:0] read_byte(input ccr_pkg::ccr_regs_s r, input logic [7:0] p);
        case (p)
            ccr_pkg::CCR_OFS_POC: read_byte = r.poc;
            ccr_pkg::CCR_OFS_CCC: read_byte = r.ccc;
            ccr_pkg::CCR_OFS_PTC: read_byte = r.ptc;
            default:              read_byte = 8'h00;
        endcase
    endfunction : read_byte

    assign byte_done = scl_fall && (cnt_reg == 4'h8);
    assign wr_commit = (state_reg == ccr_pkg::CCR_S_WR) && byte_done && ptr_valid(ptr_reg) && !bus_start && !bus_stop;
    assign wr_data   = sr_reg;

    always_comb begin
        state_next = state_reg;
        sr_next    = sr_reg;
        cnt_next   = cnt_reg;
        ptr_next   = ptr_reg;
        rnw_next   = rnw_reg;
        nack_next  = nack_reg;
        oe_next    = oe_reg;
        wdog_next  = 1'b0;
        host_next  = host_reg;
        regs_next  = regs_reg;
        if (wdog_expired) begin
            host_next = 1'b0;
        end
        if (bus_start) begin
            state_next = ccr_pkg::CCR_S_ADDR;
            cnt_next   = 4'h0;
            oe_next    = 1'b0;
        end else if (bus_stop) begin
            state_next = ccr_pkg::CCR_S_IDLE;
            oe_next    = 1'b0;
        end else begin
            case (state_reg)
                ccr_pkg::CCR_S_IDLE: begin
                    oe_next = 1'b0;
                end
                ccr_pkg::CCR_S_ADDR, ccr_pkg::CCR_S_REG, ccr_pkg::CCR_S_WR: begin
                    if (scl_rise && cnt_reg != 4'h8) begin
                        sr_next  = {sr_reg[6:0], sda_now};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        cnt_next = 4'h0;
                        if (state_reg == ccr_pkg::CCR_S_ADDR) begin
                            rnw_next = sr_reg[0];
                            if (sr_reg[7:1] == DEV_ADDR) begin
                                state_next = ccr_pkg::CCR_S_AACK;
                                oe_next    = 1'b1;
                            end else begin
                                state_next = ccr_pkg::CCR_S_IDLE;
                            end
                        end else if (state_reg == ccr_pkg::CCR_S_REG) begin
                            if (ptr_valid(sr_reg)) begin
                                ptr_next   = sr_reg;
                                state_next = ccr_pkg::CCR_S_RACK;
                                oe_next    = 1'b1;
                            end else begin
                                state_next = ccr_pkg::CCR_S_IDLE;
                            end
                        end else if (wr_commit) begin
                            host_next  = 1'b1;
                            ptr_next   = ptr_reg + 8'h01;
                            state_next = ccr_pkg::CCR_S_WACK;
                            oe_next    = 1'b1;
                            case (ptr_reg)
                                ccr_pkg::CCR_OFS_POC: begin
                                    if (wr_data[ccr_pkg::CCR_POC_RESET_BIT]) begin
                                        regs_next = REGS_RST;
                                    end else begin
                                        regs_next.poc = wr_data & 8'h3F;
                                    end
                                    wdog_next = wr_data[ccr_pkg::CCR_POC_WDOG_BIT];
                                end
                                ccr_pkg::CCR_OFS_CCC: regs_next.ccc = wr_data;
                                default:              regs_next.ptc = wr_data;
                            endcase
                        end else begin
                            state_next = ccr_pkg::CCR_S_IDLE;
                        end
                    end
                end
                ccr_pkg::CCR_S_AACK, ccr_pkg::CCR_S_RACK, ccr_pkg::CCR_S_WACK: begin
                    if (scl_fall) begin
                        cnt_next = 4'h0;
                        if (state_reg == ccr_pkg::CCR_S_AACK && rnw_reg) begin
                            state_next = ccr_pkg::CCR_S_RD;
                            sr_next    = read_byte(regs_reg, ptr_reg);
                            oe_next    = ~sr_next[7];
                        end else begin
                            state_next = (state_reg == ccr_pkg::CCR_S_AACK) ? ccr_pkg::CCR_S_REG
                                                                            : ccr_pkg::CCR_S_WR;
                            oe_next    = 1'b0;
                        end
                    end
                end
                ccr_pkg::CCR_S_RD: begin
                    if (scl_fall) begin
                        if (cnt_reg == 4'h7) begin
                            state_next = ccr_pkg::CCR_S_MACK;
                            oe_next    = 1'b0;
                        end else begin
                            sr_next  = {sr_reg[6:0], 1'b0};
                            cnt_next = cnt_reg + 4'h1;
                            oe_next  = ~sr_reg[6];
                        end
                    end
                end
                ccr_pkg::CCR_S_MACK: begin
                    if (scl_rise) begin
                        nack_next = sda_now;
                    end else if (scl_fall) begin
                        if (nack_reg) begin
                            state_next = ccr_pkg::CCR_S_IDLE;
                        end else begin
                            ptr_next   = ptr_reg + 8'h01;
                            sr_next    = read_byte(regs_reg, ptr_next);
                            cnt_next   = 4'h0;
                            oe_next    = ~sr_next[7];
                            state_next = ccr_pkg::CCR_S_RD;
                        end
                    end
                end
                default: begin
                    state_next = ccr_pkg::CCR_S_IDLE;
                    oe_next    = 1'b0;
                end
            endcase
        end
        if (wr_commit) begin
            host_next = 1'b1;
        end
    end

    assign fast_raw = ccr_pkg::CCR_FAST_CHARGE_CURRENT_CODE_BASE_MA
                    + 13'(ccr_pkg::CCR_FAST_CHARGE_CURRENT_CODE_STEP_MA * 13'(regs_reg.ccc[7:ccr_pkg::CCR_CCC_FAST_CHARGE_CURRENT_CODE_LSB]));
    assign pre_raw  = ccr_pkg::CCR_PRE_BASE_MA
                    + 12'(ccr_pkg::CCR_PRE_STEP_MA * 12'(regs_reg.ptc[7:ccr_pkg::CCR_PTC_PRE_LSB]));

    always_comb begin
        apply_next.charge_en    = regs_reg.poc[5:ccr_pkg::CCR_POC_MODE_LSB] == ccr_pkg::CCR_MODE_CHARGE;
        apply_next.otg_en       = regs_reg.poc[5];
        apply_next.floor_code   = regs_reg.poc[3:ccr_pkg::CCR_POC_FLOOR_LSB];
        apply_next.floor_mv     = ccr_pkg::CCR_FLOOR_BASE_MV
                                + 12'(ccr_pkg::CCR_FLOOR_STEP_MV * 12'(regs_reg.poc[3:1]));
        apply_next.otg_cap_high = regs_reg.poc[ccr_pkg::CCR_POC_CAP_BIT];
        apply_next.term_code    = regs_reg.ptc[3:ccr_pkg::CCR_PTC_TERM_LSB];
        if (regs_reg.ccc[ccr_pkg::CCR_CCC_FORCE_BIT]) begin
            apply_next.fast_ma = 13'((20'(fast_raw) * ccr_pkg::CCR_FAST_PCT) / ccr_pkg::CCR_FULL_PCT);
            apply_next.pre_ma  = 12'((20'(pre_raw) * ccr_pkg::CCR_PRE_PCT) / ccr_pkg::CCR_FULL_PCT);
        end else begin
            apply_next.fast_ma = fast_raw;
            apply_next.pre_ma  = pre_raw;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ccr_pkg::CCR_S_IDLE;
            sr_reg    <= 8'h00;
            cnt_reg   <= 4'h0;
            ptr_reg   <= 8'h00;
            rnw_reg   <= 1'b0;
            nack_reg  <= 1'b0;
            oe_reg    <= 1'b0;
            wdog_reg  <= 1'b0;
            host_reg  <= 1'b0;
            regs_reg  <= REGS_RST;
            apply_reg <= '0;
        end else begin
            state_reg <= state_next;
            sr_reg    <= sr_next;
            cnt_reg   <= cnt_next;
            ptr_reg   <= ptr_next;
            rnw_reg   <= rnw_next;
            nack_reg  <= nack_next;
            oe_reg    <= oe_next;
            wdog_reg  <= wdog_next;
            host_reg  <= host_next;
            regs_reg  <= regs_next;
            apply_reg <= apply_next;
        end
    end

    assign sda_o        = 1'b0;
    assign sda_oe       = oe_reg;
    assign wdog_restart = wdog_reg;
    assign host_mode    = host_reg;
    assign regs_view    = regs_reg;
    assign apply        = apply_reg;

    sequence s_addr_done;
        (state_reg == ccr_pkg::CCR_S_ADDR) && byte_done && !bus_start && !bus_stop;
    endsequence

    sequence s_poc_write;
        wr_commit && (ptr_reg == ccr_pkg::CCR_OFS_POC);
    endsequence

    property p_reg_reset;
        @(posedge clk) disable iff (!rst_n)
        s_poc_write ##0 wr_data[7] |=> (regs_reg == REGS_RST) ##1 (apply_reg.fast_ma == 13'h0400);
    endproperty
    a_reg_reset: assert property (p_reg_reset) else $error("Register reset did not restore defaults.");

    property p_self_clear;
        @(posedge clk) disable iff (!rst_n)
        regs_reg.poc[7:6] == 2'h0;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("Reset or restart bit did not clear.");

    property p_wdog_pulse;
        @(posedge clk) disable iff (!rst_n)
        s_poc_write ##0 wr_data[6] |=> wdog_restart ##1 !wdog_restart;
    endproperty
    a_wdog_pulse: assert property (p_wdog_pulse) else $error("Watchdog restart pulse wrong.");

    property p_wdog_cause;
        @(posedge clk) disable iff (!rst_n)
        wdog_restart |-> $past(wr_commit) && $past(ptr_reg) == ccr_pkg::CCR_OFS_POC;
    endproperty
    a_wdog_cause: assert property (p_wdog_cause) else $error("Watchdog restart without a write.");

    property p_mode;
        @(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> apply_reg.otg_en == $past(regs_reg.poc[5])
                 && apply_reg.charge_en == ($past(regs_reg.poc[5:4]) == 2'h1);
    endproperty
    a_mode: assert property (p_mode) else $error("Mode decode wrong.");

    property p_floor;
        @(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> apply_reg.floor_mv == 12'(12'hBB8 + 12'h064 * 12'($past(regs_reg.poc[3:1])));
    endproperty
    a_floor: assert property (p_floor) else $error("Voltage floor wrong.");

    property p_force;
        @(posedge clk) disable iff (!rst_n)
        $rose(regs_reg.ccc[0]) && $stable(regs_reg.ccc[7:2]) && $stable(regs_reg.ptc)
            |=> apply_reg.fast_ma < $past(apply_reg.fast_ma) && apply_reg.pre_ma < $past(apply_reg.pre_ma);
    endproperty
    a_force: assert property (p_force) else $error("Reduced current not applied.");

    property p_host;
        @(posedge clk) disable iff (!rst_n)
        wr_commit |=> host_mode;
    endproperty
    a_host: assert property (p_host) else $error("Write did not enter host mode.");

    property p_addr_ack;
        @(posedge clk) disable iff (!rst_n)
        s_addr_done ##0 (sr_reg[7:1] == DEV_ADDR) |=> sda_oe && state_reg == ccr_pkg::CCR_S_AACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("Own address not acknowledged.");

    property p_addr_nack;
        @(posedge clk) disable iff (!rst_n)
        s_addr_done ##0 (sr_reg[7:1] != DEV_ADDR) |=> !sda_oe [*2];
    endproperty
    a_addr_nack: assert property (p_addr_nack) else $error("Foreign address acknowledged.");

endmodule : ccr_charger_config_register_bank

// ==== pkg/ccr_pkg.sv ====
// Constants and types for the charger configuration register bank.
package ccr_pkg;

    localparam logic [6:0]  CCR_DEV_ADDR      = 7'h6B;
    localparam logic [7:0]  CCR_OFS_POC       = 8'h01;
    localparam logic [7:0]  CCR_OFS_CCC       = 8'h02;
    localparam logic [7:0]  CCR_OFS_PTC       = 8'h03;

    localparam logic [7:0]  CCR_POC_RST       = 8'h1B;
    localparam logic [7:0]  CCR_CCC_RST       = 8'h20;
    localparam logic [7:0]  CCR_PTC_RST       = 8'h11;

    localparam int          CCR_POC_RESET_BIT = 7;
    localparam int          CCR_POC_WDOG_BIT  = 6;
    localparam int          CCR_POC_MODE_LSB  = 4;
    localparam int          CCR_POC_FLOOR_LSB = 1;
    localparam int          CCR_POC_CAP_BIT   = 0;
    localparam int          CCR_CCC_FAST_CHARGE_CURRENT_CODE_LSB  = 2;
    localparam int          CCR_CCC_FORCE_BIT = 0;
    localparam int          CCR_PTC_PRE_LSB   = 4;
    localparam int          CCR_PTC_TERM_LSB  = 0;

    localparam logic [1:0]  CCR_MODE_CHARGE   = 2'h1;

    localparam logic [11:0] CCR_FLOOR_BASE_MV = 12'hBB8;
    localparam logic [11:0] CCR_FLOOR_STEP_MV = 12'h064;
    localparam logic [12:0] CCR_FAST_CHARGE_CURRENT_CODE_BASE_MA  = 13'h0200;
    localparam logic [12:0] CCR_FAST_CHARGE_CURRENT_CODE_STEP_MA  = 13'h0040;
    localparam logic [11:0] CCR_PRE_BASE_MA   = 12'h080;
    localparam logic [11:0] CCR_PRE_STEP_MA   = 12'h080;
    localparam logic [19:0] CCR_FAST_PCT      = 20'h00014;
    localparam logic [19:0] CCR_PRE_PCT       = 20'h00032;
    localparam logic [19:0] CCR_FULL_PCT      = 20'h00064;

    typedef struct packed {
        logic [7:0] poc;
        logic [7:0] ccc;
        logic [7:0] ptc;
    } ccr_regs_s;

    typedef struct packed {
        logic        charge_en;
        logic        otg_en;
        logic [2:0]  floor_code;
        logic [11:0] floor_mv;
        logic        otg_cap_high;
        logic [12:0] fast_ma;
        logic [11:0] pre_ma;
        logic [3:0]  term_code;
    } ccr_apply_s;

    typedef enum logic [8:0] {
        CCR_S_IDLE = 9'h001,
        CCR_S_ADDR = 9'h002,
        CCR_S_AACK = 9'h004,
        CCR_S_REG  = 9'h008,
        CCR_S_RACK = 9'h010,
        CCR_S_WR   = 9'h020,
        CCR_S_WACK = 9'h040,
        CCR_S_RD   = 9'h080,
        CCR_S_MACK = 9'h100
    } ccr_state_e;

endpackage : ccr_pkg

// ==== bench/ccr_i2c_host_model.sv ====
// Behavioural I2C host that drives the register bank's bus pins.
`timescale 1ns/100ps
module ccr_i2c_host_model (
    input  wire logic clk,     // Device clock that paces the bus
    input  wire logic sda_oe,  // Device pulling data low
    input  wire logic sda_o,   // Device drive value while enabled
    output logic      scl,     // Bus clock level
    output logic      sda      // Resolved data level with pull-up
);
    logic sda_drv = 1'b1;
    initial scl = 1'b1;
    assign sda = sda_drv & (sda_oe ? sda_o : 1'b1);

    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask : ticks

    // Data moves only while the bus clock is low and is sampled at the end of the high phase.
    task automatic bit_io(input logic b, output logic r);
        ticks(5);
        sda_drv <= b;
        ticks(5);
        scl <= 1'b1;
        ticks(10);
        r = sda;
        scl <= 1'b0;
    endtask : bit_io

    task automatic start_cond;
        ticks(5);
        sda_drv <= 1'b1;
        ticks(5);
        scl <= 1'b1;
        ticks(10);
        sda_drv <= 1'b0;
        ticks(10);
        scl <= 1'b0;
    endtask : start_cond

    task automatic stop_cond;
        ticks(5);
        sda_drv <= 1'b0;
        ticks(5);
        scl <= 1'b1;
        ticks(10);
        sda_drv <= 1'b1;
        ticks(10);
    endtask : stop_cond

    task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
        logic nb;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], nb);
            r[i] = nb;
        end
        bit_io(ack_in, nb);
        ack = ~nb;
    endtask : byte_io

    task automatic wr_reg(input logic [6:0] adr, input logic [7:0] ptr, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic       a0;
        logic       a1;
        logic       a2;
        start_cond();
        byte_io({adr, 1'b0}, 1'b1, r, a0);
        byte_io(ptr, 1'b1, r, a1);
        a2 = 1'b0;
        if (a0 && a1) begin
            byte_io(d, 1'b1, r, a2);
        end
        stop_cond();
        ok = a0 & a1 & a2;
    endtask : wr_reg

    task automatic rd_reg(input logic [6:0] adr, input logic [7:0] ptr, output logic [7:0] d, output logic ok);
        logic a0;
        logic a1;
        logic a2;
        logic an;
        start_cond();
        byte_io({adr, 1'b0}, 1'b1, d, a0);
        byte_io(ptr, 1'b1, d, a1);
        start_cond();
        byte_io({adr, 1'b1}, 1'b1, d, a2);
        byte_io(8'hFF, 1'b1, d, an);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask : rd_reg

    // Two-byte read: the host acknowledges the first byte and refuses the second.
    task automatic rd_pair(input logic [6:0] adr, input logic [7:0] ptr, output logic [7:0] d0, output logic [7:0] d1,
                           output logic ok);
        logic a0;
        logic a1;
        logic a2;
        logic an;
        start_cond();
        byte_io({adr, 1'b0}, 1'b1, d0, a0);
        byte_io(ptr, 1'b1, d0, a1);
        start_cond();
        byte_io({adr, 1'b1}, 1'b1, d0, a2);
        byte_io(8'hFF, 1'b0, d0, an);
        byte_io(8'hFF, 1'b1, d1, an);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask : rd_pair
endmodule : ccr_i2c_host_model

// ==== bench/tb_charger_config_register_bank.sv ====
// Self-checking bench for the charger configuration register bank.
`timescale 1ns/100ps
module tb_charger_config_register_bank;
    logic                clk          = 1'b0;
    logic                rst_n        = 1'b0;
    logic                wdog_expired = 1'b0;
    logic                scl;
    logic                sda;
    logic                sda_oe;
    logic                sda_o;
    logic                wdog_restart;
    logic                host_mode;
    ccr_pkg::ccr_regs_s  regs_view;
    ccr_pkg::ccr_apply_s apply;
    int                  miscompares  = 0;
    int                  checks_done  = 0;
    int                  pulses       = 0;
    logic [7:0]          rd;
    logic [7:0]          rd2;
    logic                ok;

    always #50 clk = ~clk;
    always @(posedge clk) if (wdog_restart === 1'b1) pulses <= pulses + 1;

    ccr_charger_config_register_bank DUT (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .wdog_expired(wdog_expired), .wdog_restart(wdog_restart), .host_mode(host_mode),
        .regs_view(regs_view), .apply(apply));
    ccr_i2c_host_model host (.clk(clk), .sda_oe(sda_oe), .sda_o(sda_o), .scl(scl), .sda(sda));

    task automatic chk_v(input string name, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_v

    task automatic chk_f(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_f

    function automatic logic [12:0] fast_exp(input logic [7:0] c);
        int raw;
        raw = 512 + 64 * c[7:2];
        return c[0] ? 13'(raw * 20 / 100) : 13'(raw);
    endfunction : fast_exp

    function automatic logic [11:0] pre_exp(input logic [7:0] p, input logic f);
        int raw;
        raw = 128 + 128 * p[7:4];
        return f ? 12'(raw / 2) : 12'(raw);
    endfunction : pre_exp

    task automatic chk_apply(input logic [7:0] poc, input logic [7:0] ccc, input logic [7:0] ptc);
        chk_f("charge_en", poc[5:4] == 2'h1, apply.charge_en);
        chk_f("otg_en", poc[5], apply.otg_en);
        chk_v("floor_mv", 24'(3000 + 100 * poc[3:1]), 24'(apply.floor_mv));
        chk_f("otg_cap_high", poc[0], apply.otg_cap_high);
        chk_v("fast_ma", 24'(fast_exp(ccc)), 24'(apply.fast_ma));
        chk_v("pre_ma", 24'(pre_exp(ptc, ccc[0])), 24'(apply.pre_ma));
        chk_v("term_code", 24'(ptc[3:0]), 24'(apply.term_code));
        chk_v("regs_view", {poc & 8'h3F, ccc, ptc}, regs_view);
    endtask : chk_apply

    task automatic chk_read(input logic [7:0] ptr, input logic [7:0] exp);
        host.rd_reg(7'h6B, ptr, rd, ok);
        chk_f("read ack", 1'b1, ok);
        chk_v("read data", 24'(exp), 24'(rd));
    endtask : chk_read

    task automatic t_defaults;
        chk_f("host_mode", 1'b0, host_mode);
        chk_apply(8'h1B, 8'h20, 8'h11);
        chk_read(8'h01, 8'h1B);
        chk_read(8'h02, 8'h20);
        chk_read(8'h03, 8'h11);
        $display("test defaults done");
    endtask : t_defaults

    task automatic t_currents;
        host.wr_reg(7'h6B, 8'h02, 8'hFE, ok);
        host.wr_reg(7'h6B, 8'h03, 8'hF3, ok);
        chk_f("host_mode", 1'b1, host_mode);
        chk_apply(8'h1B, 8'hFE, 8'hF3);
        chk_read(8'h02, 8'hFE);
        host.wr_reg(7'h6B, 8'h02, 8'hFD, ok);
        chk_apply(8'h1B, 8'hFD, 8'hF3);
        $display("test currents done");
    endtask : t_currents

    task automatic t_modes;
        logic [7:0] poc;
        for (int m = 0; m < 4; m++) begin
            poc = {2'h0, 2'(m), 2'(m), 1'(m), 1'(m)};
            host.wr_reg(7'h6B, 8'h01, poc, ok);
            chk_apply(poc, 8'hFD, 8'hF3);
            chk_read(8'h01, poc);
        end
        chk_v("restart pulses", 24'h0, 24'(pulses));
        $display("test modes done");
    endtask : t_modes

    task automatic t_wdog;
        host.wr_reg(7'h6B, 8'h01, 8'h5B, ok);
        chk_v("restart pulses", 24'h1, 24'(pulses));
        chk_read(8'h01, 8'h1B);
        @(posedge clk);
        wdog_expired <= 1'b1;
        @(posedge clk);
        wdog_expired <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk_f("host_mode", 1'b0, host_mode);
        $display("test watchdog done");
    endtask : t_wdog

    task automatic t_reg_reset;
        host.wr_reg(7'h6B, 8'h01, 8'h80, ok);
        chk_apply(8'h1B, 8'h20, 8'h11);
        chk_read(8'h01, 8'h1B);
        chk_f("host_mode", 1'b1, host_mode);
        $display("test register reset done");
    endtask : t_reg_reset

    task automatic t_multi;
        host.rd_pair(7'h6B, 8'h02, rd, rd2, ok);
        chk_f("multi-read ack", 1'b1, ok);
        chk_v("multi-read first", 24'h20, 24'(rd));
        chk_v("multi-read second", 24'h11, 24'(rd2));
        host.rd_pair(7'h6B, 8'h03, rd, rd2, ok);
        chk_v("read past end first", 24'h11, 24'(rd));
        chk_v("read past end second", 24'h00, 24'(rd2));
        $display("test multi-read done");
    endtask : t_multi

    task automatic t_refuse;
        host.wr_reg(7'h6A, 8'h02, 8'h55, ok);
        chk_f("foreign address ack", 1'b0, ok);
        host.wr_reg(7'h6B, 8'h04, 8'h55, ok);
        chk_f("pointer 04 ack", 1'b0, ok);
        host.wr_reg(7'h6B, 8'h00, 8'h55, ok);
        chk_f("pointer 00 ack", 1'b0, ok);
        chk_v("regs_view", 24'h1B2011, regs_view);
        $display("test refusals done");
    endtask : t_refuse

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #(6_000_000);
        miscompares++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_defaults();
        t_currents();
        t_modes();
        t_wdog();
        t_reg_reset();
        t_multi();
        t_refuse();
        print_verdict();
    end
endmodule : tb_charger_config_register_bank
